// File: verilog/cmlr_pkg.sv
package cmlr_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [3:0] ADDR_BUS_OUT_IMAGE = 4'h0;
   localparam logic [3:0] ADDR_BUS_IN_IMAGE  = 4'h1;
   localparam logic [3:0] ADDR_CONTROL_BITS  = 4'h2;
   localparam logic [3:0] ADDR_MODE          = 4'h3;

   // ****************************************
   // field positions
   // ****************************************
   localparam int POS_PARITY_OUT   = 8;
   localparam int POS_OPERATIONAL  = 15;
   localparam int POS_SELECT_IN    = 14;
   localparam int POS_CLOCK_OUT    = 9;
   localparam int POS_BUS_IN_PAR   = 8;
   localparam int POS_MODE_ONLINE  = 0;
   localparam int POS_MODE_CABLED  = 1;
   localparam int POS_MODE_FASTBSY = 2;
   localparam int POS_CB_ONLINE    = 0;
   localparam int POS_CB_SELECT    = 1;
   localparam int POS_CB_CLEARED   = 2;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [15:0] RST_BUS_OUT = 16'h0000;
   localparam logic [15:0] RST_BUS_IN  = 16'h0000;
   localparam logic [15:0] RST_CTRL    = 16'h0000;
   localparam logic [2:0]  RST_MODE    = 3'h0;

   // one register bus request
   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } cmlr_req_t;

endpackage : cmlr_pkg

// File: verilog/cmlr_odd_parity.sv
`timescale 1ns/1ns
`default_nettype none
// odd parity: bit is one when the data holds an even count of ones
module cmlr_odd_parity #(
   parameter int WIDTH = 8
) (
   input  wire logic [WIDTH-1:0] data,
   input  wire logic             par_in,
   output var  logic             par_gen,
   output var  logic             par_good
);
   // ****************************************
   // generator and checker
   // ****************************************
   assign par_gen  = ~(^data);
   assign par_good = (^data) ^ par_in;   // odd total of all nine bits is good
endmodule : cmlr_odd_parity
`default_nettype wire

// File: verilog/cmlr_sync3.sv
`timescale 1ns/1ns
`default_nettype none
// three stage synchroniser; a change counts once stages two and three agree
module cmlr_sync3 #(
   parameter int WIDTH = 1
) (
   input  wire logic             mclk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] d,
   output var  logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;
   logic [WIDTH-1:0] q_reg;
   // ****************************************
   // stages
   // ****************************************
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         q_reg  <= '0;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         q_reg  <= (s2_reg == s3_reg) ? s3_reg : q_reg;
      end
   end
   assign q = q_reg;
endmodule : cmlr_sync3
`default_nettype wire

// File: verilog/cmlr_maint_regs.sv
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module cmlr_maint_regs (
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        host_init,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output var  logic [15:0] reg_rdata,
   // channel bus-out side, from cable pins
   input  wire logic [15:0] cable_bus_out,
   input  wire logic        cable_clock_out,
   input  wire logic [15:0] test_in_plug,
   // internal core events
   input  wire logic [15:0] core_bus_in_load,
   input  wire logic        core_bus_in_we,
   input  wire logic        core_bus_in_clear,
   input  wire logic        core_online_req,
   input  wire logic        core_select_set,
   // channel bus-in pins (enable low while driving)
   output var  logic [15:0] bus_in_o,
   output var  logic        bus_in_oe_n,
   // bus-out test plug
   output var  logic [7:0]  test_bus_out_data,
   output var  logic        test_parity_out,
   output var  logic        test_clock_out,
   output var  logic        bus_out_parity_err
);
   // ****************************************
   // request bundle and synchronised pins
   // ****************************************
   cmlr_pkg::cmlr_req_t req;
   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   logic [15:0] cable_s;
   logic [15:0] plug_s;
   logic        clk_out_s;

   cmlr_sync3 #(.WIDTH(16)) u_sync_cable (
      .mclk (mclk),
      .nrst (nrst),
      .d    (cable_bus_out),
      .q    (cable_s)
   );
   cmlr_sync3 #(.WIDTH(16)) u_sync_plug (
      .mclk (mclk),
      .nrst (nrst),
      .d    (test_in_plug),
      .q    (plug_s)
   );
   cmlr_sync3 #(.WIDTH(1)) u_sync_clk (
      .mclk (mclk),
      .nrst (nrst),
      .d    (cable_clock_out),
      .q    (clk_out_s)
   );

   // ****************************************
   // state
   // ****************************************
   logic [15:0] bus_out_write_buffer_reg;
   logic [15:0] bus_in_store_reg;    // bit 9 and 8 positions unused
   logic [15:0] control_bits_reg;
   logic [2:0]  mode_reg;
   logic [15:0] reg_rdata_reg;
   logic [15:0] bus_in_o_reg;
   logic        bus_in_oe_n_reg;
   logic [7:0]  tbo_data_reg;
   logic        tbo_par_reg;
   logic        tbo_clk_reg;
   logic        perr_reg;

   // ****************************************
   // decode
   // ****************************************
   wire wr_bo   = req.wr && (req.addr == cmlr_pkg::ADDR_BUS_OUT_IMAGE);
   wire wr_bi   = req.wr && (req.addr == cmlr_pkg::ADDR_BUS_IN_IMAGE);
   wire wr_mode = req.wr && (req.addr == cmlr_pkg::ADDR_MODE);
   wire online  = mode_reg[cmlr_pkg::POS_MODE_ONLINE];
   wire cabled  = mode_reg[cmlr_pkg::POS_MODE_CABLED];
   wire fastbsy = mode_reg[cmlr_pkg::POS_MODE_FASTBSY];
   // off-line, or on-line with test cabling, accepts bus-out writes
   wire bo_wr_ok = !online || cabled;

   // ****************************************
   // parity on bus-in byte and on the bus-out view
   // ****************************************
   logic bus_in_parity;
   logic bo_gen_unused;
   logic bo_par_good;
   logic bi_good_unused;
   cmlr_odd_parity #(.WIDTH(8)) u_par_bi (
      .data     (bus_in_store_reg[7:0]),   // always fed by data byte
      .par_in   (1'b0),
      .par_gen  (bus_in_parity),           // no storage of its own
      .par_good (bi_good_unused)
   );
   // bus-out seen by the device: cable when on-line uncabled, else buffer
   wire [15:0] bus_out_view = (online && !cabled) ? cable_s : bus_out_write_buffer_reg;
   cmlr_odd_parity #(.WIDTH(8)) u_par_bo (
      .data     (bus_out_view[7:0]),
      .par_in   (bus_out_view[cmlr_pkg::POS_PARITY_OUT]),
      .par_gen  (bo_gen_unused),
      .par_good (bo_par_good)
   );

   // ****************************************
   // bus-in image composition
   // ****************************************
   wire [15:0] bus_in_image = {bus_in_store_reg[15:10], clk_out_s,
                               bus_in_parity, bus_in_store_reg[7:0]};
   wire [15:0] bus_in_read  = online ? plug_s : bus_in_image;

   // read mux; unmapped addresses read zero
   wire [15:0] rd_mux =
      (req.addr == cmlr_pkg::ADDR_BUS_OUT_IMAGE) ? bus_out_view :
      (req.addr == cmlr_pkg::ADDR_BUS_IN_IMAGE)  ? bus_in_read :
      (req.addr == cmlr_pkg::ADDR_CONTROL_BITS)  ? control_bits_reg :
      (req.addr == cmlr_pkg::ADDR_MODE)          ? {13'h0000, mode_reg} : 16'h0000;

   // writable bus-in bits: all but clock-out test and parity
   localparam logic [15:0] BI_WMASK = ~((16'h0001 << cmlr_pkg::POS_CLOCK_OUT) |
                                        (16'h0001 << cmlr_pkg::POS_BUS_IN_PAR));
   // select-in keeps its value through the direct clear
   localparam logic [15:0] BI_CLRMASK = 16'h0001 << cmlr_pkg::POS_SELECT_IN;

   wire [15:0] bus_in_next =
      wr_bi ? ((req.wdata & BI_WMASK) | (bus_in_store_reg & ~BI_WMASK)) :
      core_bus_in_we ? core_bus_in_load :
      core_bus_in_clear ? (bus_in_store_reg & BI_CLRMASK) :
      bus_in_store_reg;

   // control bits: hardware only, host writes ignored; bit 2 notes a direct
   // clear of bus-in so diagnostics can see one happened; init spares bits 0, 1
   localparam logic [15:0] CB_KEEP = (16'h0001 << cmlr_pkg::POS_CB_ONLINE) |
                                     (16'h0001 << cmlr_pkg::POS_CB_SELECT);
   wire [15:0] cb_set = {13'h0000, core_bus_in_clear, core_select_set, core_online_req};
   wire [15:0] control_bits_next =
      host_init ? ((control_bits_reg & CB_KEEP) | cb_set) :
      (control_bits_reg | cb_set);

   // ****************************************
   // register updates
   // ****************************************
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         bus_out_write_buffer_reg <= cmlr_pkg::RST_BUS_OUT;
         bus_in_store_reg         <= cmlr_pkg::RST_BUS_IN;
         control_bits_reg         <= cmlr_pkg::RST_CTRL;
         mode_reg                 <= cmlr_pkg::RST_MODE;
      end else begin
         // writes land in the buffer only, never on the live cable view
         if (wr_bo && bo_wr_ok) begin
            bus_out_write_buffer_reg <= req.wdata;
         end
         if (wr_mode) begin
            mode_reg <= req.wdata[2:0];
         end
         bus_in_store_reg <= bus_in_next;
         control_bits_reg <= control_bits_next;
      end
   end

   // ****************************************
   // outputs, all registered
   // ****************************************
   // clock-out follows the written parity bit only when on-line in cabled test mode
   wire clk_next = (online && cabled) ? bus_out_write_buffer_reg[cmlr_pkg::POS_PARITY_OUT]
                                      : 1'b0;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata_reg   <= 16'h0000;
         bus_in_o_reg    <= 16'h0000;
         bus_in_oe_n_reg <= 1'b1;
         tbo_data_reg    <= 8'h00;
         tbo_par_reg     <= 1'b0;
         tbo_clk_reg     <= 1'b0;
         perr_reg        <= 1'b0;
      end else begin
         reg_rdata_reg   <= req.rd ? rd_mux : 16'h0000;
         bus_in_o_reg    <= bus_in_image;
         bus_in_oe_n_reg <= !(bus_in_store_reg[cmlr_pkg::POS_OPERATIONAL] || fastbsy);
         tbo_data_reg    <= bus_out_write_buffer_reg[7:0];
         tbo_par_reg     <= bus_out_write_buffer_reg[cmlr_pkg::POS_PARITY_OUT];
         tbo_clk_reg     <= clk_next;
         perr_reg        <= !bo_par_good;
      end
   end

   assign reg_rdata          = reg_rdata_reg;
   assign bus_in_o           = bus_in_o_reg;
   assign bus_in_oe_n        = bus_in_oe_n_reg;
   assign test_bus_out_data  = tbo_data_reg;
   assign test_parity_out    = tbo_par_reg;
   assign test_clock_out     = tbo_clk_reg;
   assign bus_out_parity_err = perr_reg;

endmodule : cmlr_maint_regs
`default_nettype wire

// File: verification/cmlr_maint_checker.sv
`timescale 1ns/1ns
`default_nettype none
module cmlr_maint_checker (
   input wire logic        mclk,
   input wire logic        nrst,
   input wire logic        host_init,
   input wire logic [3:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic [15:0] cable_bus_out,
   input wire logic        cable_clock_out,
   input wire logic [15:0] test_in_plug,
   input wire logic [15:0] core_bus_in_load,
   input wire logic        core_bus_in_we,
   input wire logic        core_bus_in_clear,
   input wire logic        core_online_req,
   input wire logic        core_select_set,
   input wire logic [15:0] bus_in_o,
   input wire logic        bus_in_oe_n,
   input wire logic [7:0]  test_bus_out_data,
   input wire logic        test_parity_out,
   input wire logic        test_clock_out,
   input wire logic        bus_out_parity_err
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   logic [2:0] mode_reg;
   wire        rd_bi  = reg_rd && reg_addr == cmlr_pkg::ADDR_BUS_IN_IMAGE;
   wire        wr_bi  = reg_wr && reg_addr == cmlr_pkg::ADDR_BUS_IN_IMAGE;
   wire        rd_off = rd_bi && !mode_reg[0];
   wire        rd_cb  = reg_rd && reg_addr == cmlr_pkg::ADDR_CONTROL_BITS;
   // shadow of the mode register so checks can tell on-line from off-line
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) mode_reg <= 3'h0;
      else if (reg_wr && reg_addr == cmlr_pkg::ADDR_MODE) mode_reg <= reg_wdata[2:0];
   end
   sequence s_cabled; (mode_reg[1:0] == 2'h3)[*3]; endsequence
   sequence s_clearing; (core_bus_in_clear && !core_bus_in_we && !wr_bi)[*3]; endsequence
   sequence s_init_then_read;
      (host_init && !core_bus_in_clear) ##1 !core_bus_in_clear ##1 rd_cb;
   endsequence
   a_clock_needs_parity: assert property (test_clock_out |-> test_parity_out)
      else $error("clock-out test high without parity-out");
   a_cabled_double_duty: assert property (s_cabled |-> test_clock_out == test_parity_out)
      else $error("clock-out test differs from parity-out in cabled mode");
   a_drive_cause: assert property (!bus_in_oe_n |->
      bus_in_o[15] || $past(bus_in_o[15]) || mode_reg[2] || $past(mode_reg[2]))
      else $error("bus-in driven without operational-in or fast busy");
   a_parity_generated: assert property ($past(rd_off) |->
      reg_rdata[8] == ~^reg_rdata[7:0])
      else $error("bus-in parity not odd parity of data byte");
   a_clock_from_cable: assert property (($stable(cable_clock_out))[*6] ##0 rd_off |=>
      reg_rdata[9] == $past(cable_clock_out))
      else $error("clock-out test bit does not follow cable");
   a_plug_read_online: assert property (($stable(test_in_plug))[*6] ##0
      (rd_bi && mode_reg[0]) |=> reg_rdata == $past(test_in_plug))
      else $error("on-line bus-in read not from test-in plug");
   a_select_survives: assert property (s_clearing |-> $stable(bus_in_o[14])
      && bus_in_o[13:10] == 4'h0 && bus_in_o[7:0] == 8'h00)
      else $error("direct clear wrong on bus-in bits");
   a_ctrl_upper_zero: assert property ($past(rd_cb) |-> reg_rdata[15:3] == 13'h0000)
      else $error("unused control bits not zero");
   a_init_clears_diag: assert property (s_init_then_read |=>
      !reg_rdata[cmlr_pkg::POS_CB_CLEARED])
      else $error("host init left the clear-seen control bit set");
endmodule : cmlr_maint_checker
bind cmlr_maint_regs cmlr_maint_checker i_chk (.*);
`default_nettype wire

// File: verification/cmlr_chan_model.sv
`timescale 1ns/1ns
`default_nettype none
// channel cable and test plugs; cabled means bus-out and test plugs joined
module cmlr_chan_model (
   input  wire logic        mclk,
   input  wire logic        cabled,
   input  wire logic [7:0]  ch_byte,
   input  wire logic        ch_clock,
   input  wire logic [15:0] bus_in_o,
   input  wire logic        bus_in_oe_n,
   input  wire logic [7:0]  test_bus_out_data,
   input  wire logic        test_parity_out,
   input  wire logic        test_clock_out,
   output var  logic [15:0] cable_bus_out,
   output var  logic        cable_clock_out,
   output var  logic [15:0] test_in_plug
);
   logic [15:0] last_bus_in = 16'h0000;
   // released plug shows the inverse, never a stale copy that could pass
   always @(posedge mclk) if (!bus_in_oe_n) last_bus_in <= bus_in_o;
   always_comb begin
      cable_bus_out = cabled ? {7'h00, test_parity_out, test_bus_out_data}
                             : {7'h00, ~^ch_byte, ch_byte};
      cable_clock_out = cabled ? test_clock_out : ch_clock;
      test_in_plug = (cabled && !bus_in_oe_n) ? bus_in_o : ~last_bus_in;
   end
endmodule : cmlr_chan_model
`default_nettype wire

// File: verification/cmlr_maint_regs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module cmlr_maint_regs_tb_top;
   localparam logic [3:0] BO = cmlr_pkg::ADDR_BUS_OUT_IMAGE;
   localparam logic [3:0] BI = cmlr_pkg::ADDR_BUS_IN_IMAGE;
   localparam logic [3:0] CB = cmlr_pkg::ADDR_CONTROL_BITS;
   localparam logic [3:0] MD = cmlr_pkg::ADDR_MODE;
   logic        mclk = 1'b0, nrst = 1'b0, host_init = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000, core_bus_in_load = 16'h0000;
   logic        core_bus_in_we = 1'b0, core_bus_in_clear = 1'b0, core_online_req = 1'b0;
   logic        core_select_set = 1'b0, cabled = 1'b0, ch_clock = 1'b0, rd_seen = 1'b0;
   logic [7:0]  ch_byte = 8'h00, test_bus_out_data;
   logic [15:0] reg_rdata, cable_bus_out, test_in_plug, bus_in_o, v, me, mm;
   logic        cable_clock_out, bus_in_oe_n, test_parity_out, test_clock_out;
   logic        bus_out_parity_err;
   logic [15:0] exp_q[$], msk_q[$];
   int          num_errors = 0, check_count = 0, seed = 32'h52cd;
   cmlr_maint_regs i_dut (.*);
   cmlr_chan_model i_chan (.*);
   initial forever #5 mclk = ~mclk;
   // ****************************************
   // bus tasks and read monitor
   // ****************************************
   task automatic op(input logic w, input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
   endtask : op
   task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      op(1'b0, a, 16'h0000);
   endtask : rd
   task automatic wait_n(input int n);
      repeat (n) @(posedge mclk);
   endtask : wait_n
   task automatic end_of_test;
      if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_of_test
   // read data stands only in the cycle after the strobe, so sample it there
   always @(negedge mclk) begin
      if (rd_seen) begin
         mm = msk_q.pop_front();
         me = exp_q.pop_front();
         `CHK("reg_rdata", me, reg_rdata & mm)
      end
      rd_seen = reg_rd;
   end
   initial begin
      #500000;
      num_errors++;
      end_of_test();
   end
   initial begin
      wait_n(10);
      nrst <= 1'b1;
      rd(BO, 16'h0000, 16'hFFFF);
      rd(BI, 16'h0100, 16'hFFFF);
      op(1'b1, CB, 16'hFFFF);
      for (int a = 2; a < 16; a++) if (a != 3) rd(a[3:0], 16'h0000, 16'hFFFF);
      // off-line: good odd parity on even passes, deliberately bad on odd ones
      for (int i = 0; i < 8; i++) begin
         v = 16'($random(seed));
         v[8] = ~^v[7:0] ^ i[0];
         op(1'b1, BO, v);
         rd(BO, v, 16'h01FF);
         wait_n(4);
         `CHK("parity err", ~^v[8:0], bus_out_parity_err)
      end
      ch_clock <= 1'b1;
      v = 16'($random(seed)) | 16'h8000;
      op(1'b1, BI, v);
      wait_n(6);
      rd(BI, {v[15:10], 1'b1, ~^v[7:0], v[7:0]}, 16'hFFFF);
      `CHK("bus-in byte", v[7:0], bus_in_o[7:0])
      `CHK("bus-in enable", 1'b0, bus_in_oe_n)
      core_bus_in_load <= 16'($random(seed)) & 16'h7CFF;
      core_bus_in_we <= 1'b1;
      wait_n(1);
      core_bus_in_we <= 1'b0;
      wait_n(3);
      `CHK("bus-in enable", 1'b1, bus_in_oe_n)
      v = core_bus_in_load;
      rd(BI, {v[15:10], 1'b1, ~^v[7:0], v[7:0]}, 16'hFFFF);
      core_bus_in_clear <= 1'b1;
      wait_n(3);
      core_bus_in_clear <= 1'b0;
      rd(BI, {1'b0, v[14], 6'h03, 8'h00}, 16'hFFFF);
      op(1'b1, MD, 16'h0004);
      wait_n(3);
      `CHK("fast busy enable", 1'b0, bus_in_oe_n)
      // on-line with plugs joined: parity-out also drives clock-out
      cabled <= 1'b1;
      op(1'b1, MD, 16'h0003);
      for (int i = 0; i < 2; i++) begin
         v = {7'h00, i[0], 8'($random(seed))};
         op(1'b1, BO, v);
         wait_n(4);
         `CHK("clock-out", i[0], test_clock_out)
         `CHK("parity-out", i[0], test_parity_out)
         `CHK("test data", v[7:0], test_bus_out_data)
      end
      v = 16'($random(seed)) | 16'h8000;
      op(1'b1, BI, v);
      wait_n(6);
      rd(BI, v, 16'hFCFF);
      // on-line on live cable: host writes must not reach the cable view
      cabled <= 1'b0;
      ch_byte <= 8'($random(seed));
      op(1'b1, MD, 16'h0001);
      op(1'b1, BO, 16'h01FF);
      wait_n(6);
      rd(BO, {7'h00, ~^ch_byte, ch_byte}, 16'h01FF);
      core_online_req <= 1'b1;
      core_select_set <= 1'b1;
      wait_n(1);
      core_online_req <= 1'b0;
      core_select_set <= 1'b0;
      rd(CB, 16'h0007, 16'hFFFF);
      host_init <= 1'b1;
      wait_n(1);
      host_init <= 1'b0;
      rd(CB, 16'h0003, 16'hFFFF);
      wait_n(3);
      end_of_test();
   end
endmodule : cmlr_maint_regs_tb_top
`default_nettype wire
